// ===== rtl/tec_consts.svh
// Register offsets, field positions, reset values and timing counts of the event timer.
`ifndef TEC_CONSTS_SVH
`define TEC_CONSTS_SVH
`define TEC_OFS_COUNT 12'h000
`define TEC_OFS_PRELOAD 12'h004
`define TEC_OFS_CTRL 12'h008
`define TEC_OFS_IRQ 12'h00c
`define TEC_OFS_STATUS 12'h010
`define TEC_CTRL_MODE_HI 7
`define TEC_CTRL_MODE_LO 6
`define TEC_CTRL_RUN 4
`define TEC_CTRL_EDGE 3
`define TEC_CTRL_PSC_HI 2
`define TEC_CTRL_PSC_LO 0
`define TEC_CTRL_RESET 8'h08
`define TEC_CTRL_WMASK 8'hdf
`define TEC_PRELOAD_RESET 8'h00
`define TEC_COUNT_FULL 8'hff
`define TEC_CLK_DIV4 4
`define TEC_SLOW_SYNC_DEPTH 2
`endif

// ===== rtl/tec_pkg.sv
// Types shared by the event timer files.
package tec_pkg;
    typedef enum logic [1:0] {
        TEC_MODE_NONE = 2'b00,
        TEC_MODE_EVENT = 2'b01,
        TEC_MODE_TIMER = 2'b10,
        TEC_MODE_PULSE = 2'b11
    } tec_mode_e;
    typedef enum logic [1:0] {
        TEC_CLK_SYS = 2'b00,
        TEC_CLK_SYS_DIV4 = 2'b01,
        TEC_CLK_SLOW = 2'b10
    } tec_clksel_e;
    typedef enum logic [1:0] {
        TEC_PW_IDLE = 2'b00,
        TEC_PW_WAIT = 2'b01,
        TEC_PW_MEASURE = 2'b10
    } tec_pw_e;
endpackage

// ===== rtl/tec_tick_if.sv
// Prescaled count tick carried from the prescaler to the timer core.
`timescale 1ns/100ps
interface tec_tick_if;
    logic [2:0] psc_sel;
    logic clear;
    logic tick;
    modport core (output psc_sel, output clear, input tick);
    modport psc (input psc_sel, input clear, output tick);
endinterface

// ===== rtl/tec_prescaler.sv
// Internal count clock selection and power-of-two prescaler.
`timescale 1ns/100ps
`include "tec_consts.svh"
module tec_prescaler (
    input wire logic mclk,
    input wire logic rst_b,
    input wire tec_pkg::tec_clksel_e clk_sel,
    input wire logic slow_rc_osc,
    input wire logic stall,
    tec_tick_if.psc tk
);
    import tec_pkg::*;
    typedef struct packed {
        logic [1:0] div4;
        logic [1:0] slow_sync;
        logic slow_d;
        logic [6:0] psc;
    } tec_psc_s;
    tec_psc_s st_r;
    tec_psc_s st_nxt;
    logic src_en;
    logic [7:0] psc_ext;
    always_comb begin
        st_nxt = st_r;
        src_en = 1'b0;
        st_nxt.slow_sync = {st_r.slow_sync[0], slow_rc_osc};
        st_nxt.slow_d = st_r.slow_sync[1];
        st_nxt.div4 = st_r.div4 + 2'h1;
        // Source enable pulse from the chosen internal clock.
        case (clk_sel)
            TEC_CLK_SYS: src_en = 1'b1;
            TEC_CLK_SYS_DIV4: src_en = (st_r.div4 == 2'h3);
            TEC_CLK_SLOW: src_en = st_r.slow_d & ~st_r.slow_sync[1];
            default: src_en = 1'b0;
        endcase
        psc_ext = {1'b0, st_r.psc} + 8'h01;
        tk.tick = 1'b0;
        if (tk.clear) begin
            st_nxt.psc = 7'h00;
        end else if (src_en && !stall) begin
            st_nxt.psc = psc_ext[6:0];
            // Tick marks the falling half of the divided clock, one pulse per period.
            tk.tick = ((psc_ext & ((8'h01 << tk.psc_sel) - 8'h01)) == 8'h00);
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule // tec_prescaler

// ===== rtl/tec_timer.sv
// 8-bit count-up timer and event counter with preload, reached over APB.
//
// Contract
// - Counter adds one per qualifying prescaled tick or external edge.
// - At FFH overflow raise request, reload preload, keep counting.
// - Preload write while stopped also loads the counter at once.
// - Preload write while running waits for the next overflow reload.
// - Control bits 7:6 pick none, event, timer or pulse width mode.
// - Control bit 4 runs counting when set, holds value when clear.
// - Control bit 5 is unimplemented and reads zero.
// - Control bits 2:0 divide the internal clock by two to that power.
// - External clocking ignores the prescaler; each qualifying edge counts.
// - Event mode edge select 0 counts rising, 1 counts falling edges.
// - Pulse mode edge select 0 measures low pulse, 1 measures high pulse.
// - Timer mode advances on each falling edge of the prescaled clock.
// - Overflow serves as a wake-up source out of power-down.
// - Overflow request is forwarded only while its enable bit is set.
// - Event mode uses the external pin unprescaled as count clock.
// - Event mode counts during sleep; overflow then interrupts and wakes.
// - Pulse mode waits for edge, clears run bit at return, ignores rest.
// - Counting is inhibited during counter reads and preload writes.
`timescale 1ns/100ps
`include "tec_consts.svh"
module tec_timer (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tec_pkg::tec_clksel_e clk_sel,
    input wire logic slow_rc_osc,
    input wire logic ext_count_pin,
    input wire logic sleep,
    output logic overflow_irq,
    output logic wake_req
);
    import tec_pkg::*;
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] preload;
        logic [7:0] ctrl;
        logic irq_en;
        logic irq_flag;
        logic [1:0] pin_sync;
        logic pin_d;
        tec_pw_e pw;
        logic [31:0] rdata;
    } tec_core_s;
    tec_core_s st_r;
    tec_core_s st_nxt;
    tec_tick_if tk ();
    logic acc;
    logic wr;
    logic rd;
    logic rd_setup;
    logic hit;
    logic inhibit;
    logic rise;
    logic fall;
    logic act_edge;
    logic stop_edge;
    logic inc;
    logic ovf;
    logic [7:0] wb;
    tec_mode_e mode;
    tec_prescaler u_psc (
        .mclk(mclk),
        .rst_b(rst_b),
        .clk_sel(clk_sel),
        .slow_rc_osc(slow_rc_osc),
        .stall(inhibit),
        .tk(tk)
    );
    assign pready = 1'b1;
    assign prdata = st_r.rdata;
    assign overflow_irq = st_r.irq_flag & st_r.irq_en;
    assign wake_req = overflow_irq & sleep;
    always_comb begin
        st_nxt = st_r;
        acc = psel & penable;
        wr = acc & pwrite;
        rd = acc & ~pwrite;
        rd_setup = psel & ~penable & ~pwrite;
        wb = pwdata[7:0];
        hit = (paddr == `TEC_OFS_COUNT) || (paddr == `TEC_OFS_PRELOAD)
            || (paddr == `TEC_OFS_CTRL) || (paddr == `TEC_OFS_IRQ)
            || (paddr == `TEC_OFS_STATUS);
        pslverr = acc & ~hit;
        // Freezing the count around the access keeps the value software sees coherent.
        inhibit = (psel && !pwrite && paddr == `TEC_OFS_COUNT)
            || (wr && paddr == `TEC_OFS_PRELOAD);
        mode = tec_mode_e'(st_r.ctrl[`TEC_CTRL_MODE_HI:`TEC_CTRL_MODE_LO]);
        tk.psc_sel = st_r.ctrl[`TEC_CTRL_PSC_HI:`TEC_CTRL_PSC_LO];
        tk.clear = ~st_r.ctrl[`TEC_CTRL_RUN] | (mode != TEC_MODE_TIMER && mode != TEC_MODE_PULSE);
        st_nxt.pin_sync = {st_r.pin_sync[0], ext_count_pin};
        st_nxt.pin_d = st_r.pin_sync[1];
        rise = st_r.pin_sync[1] & ~st_r.pin_d;
        fall = ~st_r.pin_sync[1] & st_r.pin_d;
        act_edge = st_r.ctrl[`TEC_CTRL_EDGE] ? rise : fall;
        stop_edge = st_r.ctrl[`TEC_CTRL_EDGE] ? fall : rise;
        inc = 1'b0;
        if (st_r.ctrl[`TEC_CTRL_RUN] && !inhibit) begin
            case (mode)
                TEC_MODE_EVENT: inc = st_r.ctrl[`TEC_CTRL_EDGE] ? fall : rise;
                TEC_MODE_TIMER: inc = tk.tick;
                TEC_MODE_PULSE: inc = (st_r.pw == TEC_PW_MEASURE) & tk.tick & ~stop_edge;
                default: inc = 1'b0;
            endcase
        end
        // Pulse width sequencer: arm on run, measure between edges, then self-stop.
        if (!st_r.ctrl[`TEC_CTRL_RUN] || mode != TEC_MODE_PULSE) begin
            st_nxt.pw = TEC_PW_IDLE;
        end else begin
            case (st_r.pw)
                TEC_PW_IDLE: st_nxt.pw = TEC_PW_WAIT;
                TEC_PW_WAIT: if (act_edge) st_nxt.pw = TEC_PW_MEASURE;
                TEC_PW_MEASURE: begin
                    if (stop_edge) begin
                        st_nxt.pw = TEC_PW_IDLE;
                        st_nxt.ctrl[`TEC_CTRL_RUN] = 1'b0;
                    end
                end
                default: st_nxt.pw = TEC_PW_IDLE;
            endcase
        end
        ovf = inc && (st_r.count == `TEC_COUNT_FULL);
        if (inc) begin
            st_nxt.count = ovf ? st_r.preload : st_r.count + 8'h01;
        end
        if (wr) begin
            if (paddr == `TEC_OFS_PRELOAD) begin
                st_nxt.preload = wb;
                if (!st_r.ctrl[`TEC_CTRL_RUN]) begin
                    st_nxt.count = wb;
                end
            end else if (paddr == `TEC_OFS_CTRL) begin
                st_nxt.ctrl = wb & `TEC_CTRL_WMASK;
                if (!wb[`TEC_CTRL_RUN]) begin
                    st_nxt.pw = TEC_PW_IDLE;
                end
            end else if (paddr == `TEC_OFS_IRQ) begin
                st_nxt.irq_en = wb[0];
            end else if (paddr == `TEC_OFS_STATUS) begin
                if (wb[0]) begin
                    st_nxt.irq_flag = 1'b0;
                end
            end
        end
        if (ovf) begin
            st_nxt.irq_flag = 1'b1;
        end
        // Read data is captured in the setup cycle so that it stands through the access phase.
        if (rd_setup) begin
            if (paddr == `TEC_OFS_COUNT) begin
                st_nxt.rdata = {24'h000000, st_r.count};
            end else if (paddr == `TEC_OFS_PRELOAD) begin
                st_nxt.rdata = {24'h000000, st_r.preload};
            end else if (paddr == `TEC_OFS_CTRL) begin
                st_nxt.rdata = {24'h000000, st_r.ctrl & `TEC_CTRL_WMASK};
            end else if (paddr == `TEC_OFS_IRQ) begin
                st_nxt.rdata = {31'h0, st_r.irq_en};
            end else if (paddr == `TEC_OFS_STATUS) begin
                st_nxt.rdata = {29'h0, st_r.pw, st_r.irq_flag};
            end else begin
                st_nxt.rdata = 32'h00000000;
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.ctrl <= `TEC_CTRL_RESET;
            st_r.preload <= `TEC_PRELOAD_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    property p_reload;
        @(posedge mclk) disable iff (!rst_b)
        ovf |=> (st_r.count == $past(st_r.preload)) && st_r.irq_flag;
    endproperty
    a_reload: assert property (p_reload) else $error("overflow did not reload");
    property p_inc;
        @(posedge mclk) disable iff (!rst_b)
        (inc && !ovf && !(wr && paddr == `TEC_OFS_PRELOAD))
            |=> st_r.count == $past(st_r.count) + 8'h01;
    endproperty
    a_inc: assert property (p_inc) else $error("count did not step by one");
    property p_stopped_load;
        @(posedge mclk) disable iff (!rst_b)
        (wr && paddr == `TEC_OFS_PRELOAD && !st_r.ctrl[`TEC_CTRL_RUN])
            |=> st_r.count == $past(wb);
    endproperty
    a_stopped_load: assert property (p_stopped_load) else $error("stopped preload not loaded");
    property p_hold;
        @(posedge mclk) disable iff (!rst_b)
        (!st_r.ctrl[`TEC_CTRL_RUN] && !wr) |=> st_r.count == $past(st_r.count);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved while stopped");
    property p_bit5;
        @(posedge mclk) disable iff (!rst_b)
        st_r.ctrl[5] == 1'b0;
    endproperty
    a_bit5: assert property (p_bit5) else $error("control bit 5 set");
    property p_inhibit;
        @(posedge mclk) disable iff (!rst_b)
        (rd && paddr == `TEC_OFS_COUNT) |=> st_r.count == $past(st_r.count);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("count moved during read");
    property p_irq_gate;
        @(posedge mclk) disable iff (!rst_b)
        !st_r.irq_en |-> !overflow_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("masked request forwarded");
    property p_pw_stop;
        @(posedge mclk) disable iff (!rst_b)
        (st_r.pw == TEC_PW_MEASURE && stop_edge && mode == TEC_MODE_PULSE && !wr)
            |=> !st_r.ctrl[`TEC_CTRL_RUN] ##1 !st_r.ctrl[`TEC_CTRL_RUN] || wr;
    endproperty
    a_pw_stop: assert property (p_pw_stop) else $error("pulse capture did not stop");
    property p_event;
        @(posedge mclk) disable iff (!rst_b)
        (mode == TEC_MODE_EVENT && st_r.ctrl[`TEC_CTRL_RUN] && !inhibit
            && !st_r.ctrl[`TEC_CTRL_EDGE] && rise && !wr)
            |=> st_r.count == (($past(st_r.count) == `TEC_COUNT_FULL) ? $past(st_r.preload)
                : $past(st_r.count) + 8'h01);
    endproperty
    a_event: assert property (p_event) else $error("rising edge not counted");
    property p_event_fall;
        @(posedge mclk) disable iff (!rst_b)
        (mode == TEC_MODE_EVENT && st_r.ctrl[`TEC_CTRL_RUN] && !inhibit
            && st_r.ctrl[`TEC_CTRL_EDGE] && fall && !wr)
            |=> st_r.count == (($past(st_r.count) == `TEC_COUNT_FULL) ? $past(st_r.preload)
                : $past(st_r.count) + 8'h01);
    endproperty
    a_event_fall: assert property (p_event_fall) else $error("falling edge not counted");
    property p_event_noedge;
        @(posedge mclk) disable iff (!rst_b)
        (mode == TEC_MODE_EVENT && !rise && !fall) |-> !inc;
    endproperty
    a_event_noedge: assert property (p_event_noedge) else $error("event count without edge");
    property p_run_load;
        @(posedge mclk) disable iff (!rst_b)
        (wr && paddr == `TEC_OFS_PRELOAD && st_r.ctrl[`TEC_CTRL_RUN])
            |=> st_r.preload == $past(wb) && st_r.count == $past(st_r.count);
    endproperty
    a_run_load: assert property (p_run_load) else $error("running preload write wrong");
    property p_timer_only_tick;
        @(posedge mclk) disable iff (!rst_b)
        (mode == TEC_MODE_TIMER && !tk.tick) |-> !inc;
    endproperty
    a_timer_only_tick: assert property (p_timer_only_tick) else $error("timer stepped off tick");
    property p_mode_none;
        @(posedge mclk) disable iff (!rst_b)
        (mode == TEC_MODE_NONE) |-> !inc;
    endproperty
    a_mode_none: assert property (p_mode_none) else $error("count moved with no mode");
    property p_pw_wait;
        @(posedge mclk) disable iff (!rst_b)
        (mode == TEC_MODE_PULSE && st_r.pw != TEC_PW_MEASURE) |-> !inc;
    endproperty
    a_pw_wait: assert property (p_pw_wait) else $error("pulse counted before edge");
    property p_pw_arm;
        @(posedge mclk) disable iff (!rst_b)
        (mode == TEC_MODE_PULSE && st_r.ctrl[`TEC_CTRL_RUN] && st_r.pw == TEC_PW_WAIT
            && act_edge && !wr) |=> st_r.pw == TEC_PW_MEASURE;
    endproperty
    a_pw_arm: assert property (p_pw_arm) else $error("active edge did not start capture");
    property p_irq_level;
        @(posedge mclk) disable iff (!rst_b)
        (st_r.irq_en && st_r.irq_flag) |-> overflow_irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("enabled request not forwarded");
    property p_wake;
        @(posedge mclk) disable iff (!rst_b)
        (overflow_irq && sleep) |-> wake_req;
    endproperty
    a_wake: assert property (p_wake) else $error("overflow in sleep did not wake");
    property p_no_wake;
        @(posedge mclk) disable iff (!rst_b)
        !sleep |-> !wake_req;
    endproperty
    a_no_wake: assert property (p_no_wake) else $error("wake raised while awake");
    property p_flag_hold;
        @(posedge mclk) disable iff (!rst_b)
        (st_r.irq_flag && !(wr && paddr == `TEC_OFS_STATUS && wb[0])) |=> st_r.irq_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("overflow flag lost");
    property p_rd_stall;
        @(posedge mclk) disable iff (!rst_b)
        (psel && !pwrite && paddr == `TEC_OFS_COUNT) |=> st_r.count == $past(st_r.count);
    endproperty
    a_rd_stall: assert property (p_rd_stall) else $error("count moved during read");
    property p_rd_capture;
        @(posedge mclk) disable iff (!rst_b)
        (psel && !penable && !pwrite && paddr == `TEC_OFS_COUNT)
            |=> st_r.rdata == {24'h000000, $past(st_r.count)};
    endproperty
    a_rd_capture: assert property (p_rd_capture) else $error("count read not captured");
    property p_rise_sync;
        @(posedge mclk) disable iff (!rst_b)
        rise |-> $past(ext_count_pin, 2);
    endproperty
    a_rise_sync: assert property (p_rise_sync) else $error("rise not from synced pin");
    property p_fall_sync;
        @(posedge mclk) disable iff (!rst_b)
        fall |-> !$past(ext_count_pin, 2);
    endproperty
    a_fall_sync: assert property (p_fall_sync) else $error("fall not from synced pin");
endmodule // tec_timer

// ===== dv/tec_pin_src.sv
// External pulse source that toggles the timer pin on command.
`timescale 1ns/100ps
module tec_pin_src (
    input wire logic mclk,
    input wire logic go,
    input wire logic [7:0] n,
    input wire logic [7:0] gap,
    output logic pin,
    output logic busy
);
    logic [7:0] left_r;
    logic [7:0] wait_r;
    initial begin
        pin = 1'b0;
        busy = 1'b0;
    end
    // Clean transitions spaced by gap plus one cycles, so a slow or prompt source is a command away.
    always @(posedge mclk) begin
        if (go) begin
            left_r <= n;
            wait_r <= gap;
            busy <= 1'b1;
        end else if (busy) begin
            if (wait_r != 8'h00) begin
                wait_r <= wait_r - 8'h01;
            end else if (left_r == 8'h00) begin
                busy <= 1'b0;
            end else begin
                pin <= ~pin;
                left_r <= left_r - 8'h01;
                wait_r <= gap;
            end
        end
    end
endmodule // tec_pin_src

// ===== dv/tec_timer_tb.sv
// Self-checking bench for the event timer driven by an external pin source.
`timescale 1ns/100ps
`include "tec_consts.svh"
module tec_timer_tb;
    import tec_pkg::*;
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, slow_rc_osc, sleep;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    tec_clksel_e clk_sel;
    logic overflow_irq, wake_req, pin, busy, go, err;
    logic [7:0] n, gap;
    logic [2:0] sc = 3'h0;
    integer fail_count = 0, n_tests = 0, seed = 32'h09ec, e, k, p, t, r, dv;
    tec_timer u_tec_timer (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clk_sel(clk_sel), .slow_rc_osc(slow_rc_osc),
        .ext_count_pin(pin), .sleep(sleep), .overflow_irq(overflow_irq), .wake_req(wake_req));
    tec_pin_src u_tec_pin_src (.mclk(mclk), .go(go), .n(n), .gap(gap), .pin(pin), .busy(busy));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // The slow oscillator is modelled as one falling edge every 16 cycles.
    always @(posedge mclk) begin
        sc <= sc + 3'h1;
        if (sc == 3'h7) slow_rc_osc <= ~slow_rc_osc;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        n_tests++;
        if ((got < lo) !== 1'b0 || (got > hi) !== 1'b0) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        integer w;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        w = 0;
        do begin
            @(posedge mclk);
            w++;
        end while (pready !== 1'b1 && w < 20);
        if (pready !== 1'b1) fail_count++;
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge keeps a following call from raising psel in the same step.
        @(posedge mclk);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic toggle(input logic [7:0] cnt, input logic [7:0] g);
        integer w;
        n <= cnt;
        gap <= g;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        w = 0;
        do begin
            @(posedge mclk);
            w++;
        end while (busy !== 1'b0 && w < 3000);
        if (busy !== 1'b0) fail_count++;
        repeat (6) @(posedge mclk);
    endtask
    task automatic test_done();
        if (fail_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        fail_count++;
        test_done();
    end
    initial begin
        {rst_b, psel, penable, pwrite, go, sleep, slow_rc_osc} = 7'h0;
        {paddr, pwdata, n, gap} = 60'h0;
        clk_sel = TEC_CLK_SYS;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rdc(`TEC_OFS_CTRL, `TEC_CTRL_RESET);
        rdc(`TEC_OFS_COUNT, 32'h0);
        apb(1'b1, `TEC_OFS_CTRL, 32'h2f);
        rdc(`TEC_OFS_CTRL, 32'h0f);
        rdc(12'h020, 32'h0);
        chk(err, 1'b1);
        for (k = 0; k < 2; k++) begin
            r = $random(seed) & 255;
            apb(1'b1, `TEC_OFS_CTRL, 32'h08);
            apb(1'b1, `TEC_OFS_PRELOAD, r);
            rdc(`TEC_OFS_COUNT, r);
            apb(1'b1, `TEC_OFS_CTRL, k ? 32'h80 : 32'h10);
            repeat (50) @(posedge mclk);
            rdc(`TEC_OFS_COUNT, r);
        end
        for (k = 0; k < 3; k++) begin
            p = $random(seed) & 3;
            dv = (k == 0) ? 1 : (k == 1) ? 4 : 16;
            clk_sel <= tec_clksel_e'(k[1:0]);
            apb(1'b1, `TEC_OFS_CTRL, 32'h08);
            apb(1'b1, `TEC_OFS_PRELOAD, 32'h0);
            apb(1'b1, `TEC_OFS_CTRL, 32'h90 | p);
            repeat ((40 * dv) << p) @(posedge mclk);
            apb(1'b0, `TEC_OFS_COUNT, 32'h0);
            chk_rng(rd, 36, 41);
        end
        clk_sel <= TEC_CLK_SYS;
        for (e = 0; e < 4; e++) begin
            apb(1'b1, `TEC_OFS_CTRL, 32'h08);
            apb(1'b1, `TEC_OFS_PRELOAD, 32'h0);
            apb(1'b1, `TEC_OFS_CTRL, e[0] ? 32'h5f : 32'h57);
            t = ($random(seed) & 31) | 1;
            r = (pin === 1'b0) ? (t + 1) / 2 : t / 2;
            toggle(t[7:0], 8'd3 + e[7:0] * 8'd4);
            rdc(`TEC_OFS_COUNT, e[0] ? t - r : r);
        end
        apb(1'b1, `TEC_OFS_CTRL, 32'h08);
        apb(1'b1, `TEC_OFS_PRELOAD, 32'hfc);
        apb(1'b1, `TEC_OFS_IRQ, 32'h1);
        apb(1'b1, `TEC_OFS_CTRL, 32'h92);
        apb(1'b1, `TEC_OFS_PRELOAD, 32'h40);
        t = 0;
        while (overflow_irq !== 1'b1 && t < 100) begin
            @(posedge mclk);
            t++;
        end
        chk(overflow_irq, 1'b1);
        apb(1'b0, `TEC_OFS_COUNT, 32'h0);
        chk_rng(rd, 32'h40, 32'h43);
        sleep <= 1'b1;
        repeat (2) @(posedge mclk);
        chk(wake_req, 1'b1);
        apb(1'b1, `TEC_OFS_IRQ, 32'h0);
        chk(overflow_irq, 1'b0);
        apb(1'b1, `TEC_OFS_STATUS, 32'h1);
        apb(1'b1, `TEC_OFS_IRQ, 32'h1);
        apb(1'b1, `TEC_OFS_CTRL, 32'h08);
        apb(1'b1, `TEC_OFS_PRELOAD, 32'hfe);
        apb(1'b1, `TEC_OFS_CTRL, 32'h50);
        toggle(8'd4, 8'd5);
        chk(wake_req, 1'b1);
        rdc(`TEC_OFS_COUNT, 32'hfe);
        sleep <= 1'b0;
        for (e = 0; e < 2; e++) begin
            apb(1'b1, `TEC_OFS_CTRL, 32'h08);
            apb(1'b1, `TEC_OFS_PRELOAD, 32'h0);
            if (pin !== (e == 0)) toggle(8'd1, 8'd3);
            apb(1'b1, `TEC_OFS_CTRL, e ? 32'hd8 : 32'hd0);
            t = 20 + ($random(seed) & 63);
            toggle(8'd2, t[7:0]);
            apb(1'b0, `TEC_OFS_COUNT, 32'h0);
            r = rd;
            chk_rng(rd, t - 2, t + 4);
            rdc(`TEC_OFS_CTRL, e ? 32'hc8 : 32'hc0);
            toggle(8'd2, 8'd5);
            rdc(`TEC_OFS_COUNT, r);
        end
        test_done();
    end
endmodule // tec_timer_tb
